// ==== core/rqfc_top.sv ====
// Receive-queue flow control: pause/jam backpressure and queue status
module rqfc_top
   import rqfc_pkg::*;
#(
   parameter int unsigned OCC_W = RQFC_OCC_W
)
(
   input wire logic core_clk,
   input wire logic resetn,
   // Host control bits
   input wire logic auto_backpressure_enable,
   input wire logic host_flow_ctrl_enable,
   input wire logic host_pause_request,
   input wire logic jam_enable,
   input wire logic pause_response_ctrl,
   input wire logic full_duplex,
   input wire logic [15:0] pause_time,
   input wire logic [RQFC_SIZE_W-1:0] rx_queue_size,
   input wire logic [OCC_W-1:0] rx_queue_high_threshold,
   input wire logic [OCC_W-1:0] rx_queue_low_threshold,
   input wire logic status_read,
   input wire logic [OCC_W-1:0] tx_queue_high_threshold,
   input wire logic [OCC_W-1:0] tx_queue_low_threshold,
   // Queue events from the MAC and HDLC sides
   input wire logic rx_frame_start,
   input wire logic rx_enqueue,
   input wire logic rx_dequeue,
   input wire logic tx_enqueue,
   input wire logic tx_dequeue,
   input wire logic rx_pause_received,
   input wire logic [15:0] rx_pause_quanta,
   input wire logic pause_sent,
   input wire logic slot_tick,
   // MAC-side backpressure actions
   output logic pause_send_req,
   output logic [47:0] pause_dest_addr,
   output logic [15:0] pause_quanta,
   output logic jam_active,
   output logic rx_frame_drop,
   output logic tx_hold,
   // Status bits
   output logic flow_ctrl_enable,
   output logic pause_request_busy,
   output logic rx_queue_overflow_flag,
   output logic rx_high_latched,
   output logic rx_low_latched,
   output logic rx_above_high,
   output logic tx_high_latched,
   output logic tx_low_latched,
   output logic [OCC_W-1:0] rx_occupancy,
   // SDRAM arbitration
   input rqfc_xfer_req_t mac_req,
   input rqfc_xfer_req_t hdlc_req,
   output logic mac_gnt,
   output logic hdlc_gnt,
   output rqfc_xfer_req_t sdram_req,
   input wire logic sdram_done,
   input wire logic [31:0] sdram_rdata,
   output logic [31:0] sdram_rdata_q,
   output logic sdram_rdata_valid
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // Every register of the block outside u_arb lives in this one struct
   typedef struct packed {
      logic [OCC_W-1:0] rx_occ;
      logic [OCC_W-1:0] tx_occ;
      logic above_high;
      logic above_low;
      logic tx_above_high;
      logic tx_above_low;
      logic high_lat;
      logic low_lat;
      logic ovf_lat;
      logic tx_high_lat;
      logic tx_low_lat;
      logic pause_busy;
      logic fce;
      logic [2:0] jam_cnt;
      logic jam;
      logic drop;
      logic [15:0] hold_cnt;
      logic [15:0] quanta;
   } rqfc_state_t;

   rqfc_state_t s_q;
   rqfc_state_t s_d;

   logic [OCC_W:0] cap_pkts;
   // Next occupancies, shared by the counters and the threshold compares
   logic [OCC_W-1:0] rx_occ_next;
   logic [OCC_W-1:0] tx_occ_next;
   logic full;

   // capacity in units of 32 packets
   assign cap_pkts = (OCC_W+1)'(rx_queue_size) *
                     (OCC_W+1)'(RQFC_PKTS_PER_UNIT);
   // A size of zero makes the queue full at once, so every frame drops
   assign full = ({1'b0, s_q.rx_occ} >= cap_pkts);

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      rx_occ_next = s_q.rx_occ;
      tx_occ_next = s_q.tx_occ;

      // Drop is decided once per frame at its start; a frame already
      // being stored is not flagged, but its enqueues stop counting once full
      // drop new frames while full
      if (rx_frame_start)
         s_d.drop = full;
      if (rx_enqueue && !s_q.drop && !full)
         rx_occ_next = rx_occ_next + 1'b1;
      // Dequeue at zero is ignored so a stray pulse cannot wrap the
      // count and fake a full queue; same cycle in and out cancel only when the enqueue counts and the count is not zero
      if (rx_dequeue && (s_q.rx_occ != '0))
         rx_occ_next = rx_occ_next - 1'b1;
      s_d.rx_occ = rx_occ_next;

      // No backpressure is derived from these; they only feed status
      // transmit queue: counters and thresholds only
      if (tx_enqueue)
         tx_occ_next = tx_occ_next + 1'b1;
      if (tx_dequeue && (s_q.tx_occ != '0))
         tx_occ_next = tx_occ_next - 1'b1;
      s_d.tx_occ = tx_occ_next;

      // compare on every enqueue and dequeue
      s_d.above_high = (rx_occ_next > rx_queue_high_threshold);
      s_d.above_low = (rx_occ_next > rx_queue_low_threshold);
      s_d.tx_above_high = (tx_occ_next > tx_queue_high_threshold);
      s_d.tx_above_low = (tx_occ_next > tx_queue_low_threshold);

      // read clears, a new event in the same cycle wins
      if (status_read)
      begin
         s_d.high_lat = 1'b0;
         s_d.low_lat = 1'b0;
         s_d.ovf_lat = 1'b0;
         s_d.tx_high_lat = 1'b0;
         s_d.tx_low_lat = 1'b0;
      end
      // Crossing edges come from the registered level, so one crossing
      // sets its latch once however long the level stays
      if (s_d.above_high && !s_q.above_high)
         s_d.high_lat = 1'b1;
      if (!s_d.above_low && s_q.above_low)
         s_d.low_lat = 1'b1;
      if (s_d.tx_above_high && !s_q.tx_above_high)
         s_d.tx_high_lat = 1'b1;
      if (!s_d.tx_above_low && s_q.tx_above_low)
         s_d.tx_low_lat = 1'b1;
      if (rx_frame_start && full)
         s_d.ovf_lat = 1'b1;

      // In manual mode the host bit passes one flop, so the MAC sees
      // a change one cycle after the host makes it
      // device owns the bits in automatic mode
      if (auto_backpressure_enable)
         s_d.fce = 1'b1;
      else
         s_d.fce = host_flow_ctrl_enable;

      // timer frozen while a pause waits, so the frame carries
      // the value that stood when the pause was asked for
      if (!s_q.pause_busy)
         s_d.quanta = pause_time;

      // Pause request stays busy until the MAC reports it sent
      if (pause_sent)
         s_d.pause_busy = 1'b0;
      if (full_duplex && s_d.fce)
      begin
         if (auto_backpressure_enable)
         begin
            if (rx_frame_start && s_q.above_high)
               s_d.pause_busy = 1'b1;
         end
         else if (host_pause_request)
            s_d.pause_busy = 1'b1;
      end

      // The level is taken from the previous cycle, so a frame that
      // starts in the very cycle of the crossing is left alone
      // jam only new frames in half duplex
      if (rx_frame_start && !full_duplex &&
          (auto_backpressure_enable ? s_q.above_high
                                    : (jam_enable && s_d.fce)))
      begin
         s_d.jam = 1'b1;
         s_d.jam_cnt = RQFC_JAM_BYTES;
      end
      else if (s_q.jam)
      begin
         // One byte time per core_clk cycle; no strobe gates the count
         s_d.jam_cnt = s_q.jam_cnt - 3'h1;
         if (s_q.jam_cnt == 3'h1)
            s_d.jam = 1'b0;
      end

      // A new pause frame restarts the count rather than adding to it
      // honour received pause only when enabled
      if (rx_pause_received && pause_response_ctrl && full_duplex)
         s_d.hold_cnt = rx_pause_quanta;
      else if (slot_tick && (s_q.hold_cnt != '0))
         s_d.hold_cnt = s_q.hold_cnt - 16'h0001;
   end

   // State register
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q <= '0;
         s_q.fce <= RQFC_AUTO_RST;
         s_q.quanta <= RQFC_PAUSE_TIME_RST;
      end
      else
         s_q <= s_d;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The request level doubles as the busy bit seen by the host
   assign pause_send_req = s_q.pause_busy;
   assign pause_dest_addr = RQFC_PAUSE_DA;
   assign pause_quanta = s_q.quanta;
   assign jam_active = s_q.jam;
   assign rx_frame_drop = s_q.drop;
   // Hold follows the countdown; pause response control only gates the reload
   assign tx_hold = (s_q.hold_cnt != '0);
   // Status levels come straight from flops, so the host never sees
   // a glitch between two updates
   assign flow_ctrl_enable = s_q.fce;
   assign pause_request_busy = s_q.pause_busy;
   assign rx_queue_overflow_flag = s_q.ovf_lat;
   assign rx_high_latched = s_q.high_lat;
   assign rx_low_latched = s_q.low_lat;
   assign rx_above_high = s_q.above_high;
   assign tx_high_latched = s_q.tx_high_lat;
   assign tx_low_latched = s_q.tx_low_lat;
   assign rx_occupancy = s_q.rx_occ;

   // ------------------------------------------------------------
   // SDRAM arbiter
   // ------------------------------------------------------------
   // Only request handling is kept here; SDRAM timing is left to the
   // controller that answers sdram_req
   rqfc_arb u_arb (
      .core_clk(core_clk),
      .resetn(resetn),
      .mac_req(mac_req),
      .hdlc_req(hdlc_req),
      .mac_gnt(mac_gnt),
      .hdlc_gnt(hdlc_gnt),
      .sdram_req(sdram_req),
      .sdram_done(sdram_done),
      .sdram_rdata(sdram_rdata),
      .rdata(sdram_rdata_q),
      .rdata_valid(sdram_rdata_valid)
   );

endmodule : rqfc_top

// ==== core/rqfc_pkg.sv ====
// Package for the receive-queue flow control block: constants and carriers
package rqfc_pkg;

   // ------------------------------------------------------------
   // Queue geometry
   // ------------------------------------------------------------
   localparam int unsigned RQFC_PKTS_PER_UNIT = 32;
   localparam int unsigned RQFC_SLOT_BYTES = 2048;
   localparam int unsigned RQFC_SDRAM_PKTS = 8192;
   localparam int unsigned RQFC_OCC_W = 14;
   localparam int unsigned RQFC_SIZE_W = 8;

   // ------------------------------------------------------------
   // Jam and pause constants
   // ------------------------------------------------------------
   localparam logic [2:0] RQFC_JAM_BYTES = 3'h4;
   localparam logic [47:0] RQFC_PAUSE_DA = 48'h0180_6200_0001;
   localparam logic [15:0] RQFC_PAUSE_TIME_RST = 16'h0050;

   // ------------------------------------------------------------
   // Reset values of control bits
   // ------------------------------------------------------------
   localparam logic RQFC_AUTO_RST = 1'b1;
   localparam logic RQFC_PASS_CTRL_RST = 1'b0;

   // Arbiter grant owner
   typedef enum logic [1:0] {
      RQFC_OWN_IDLE,
      RQFC_OWN_MAC,
      RQFC_OWN_HDLC
   } rqfc_owner_t;

   // Transfer request from one engine to the SDRAM port
   typedef struct packed {
      logic req;
      logic wr;
      logic [22:0] addr;
      logic [31:0] wdata;
   } rqfc_xfer_req_t;

   // Host control bits
   typedef struct packed {
      logic auto_backpressure_enable;
      logic flow_ctrl_enable;
      logic pause_request_busy;
      logic jam_enable;
      logic pause_response_ctrl;
      logic full_duplex;
      logic [15:0] pause_time;
      logic [RQFC_SIZE_W-1:0] rx_queue_size;
      logic [RQFC_OCC_W-1:0] rx_queue_high_threshold;
      logic [RQFC_OCC_W-1:0] rx_queue_low_threshold;
   } rqfc_ctrl_t;

   // Status toward the host
   typedef struct packed {
      logic rx_queue_overflow_flag;
      logic high_latched;
      logic low_latched;
      logic above_high;
      logic flow_ctrl_enable;
      logic pause_request_busy;
   } rqfc_stat_t;

endpackage : rqfc_pkg

// ==== core/rqfc_arb.sv ====
// SDRAM request arbiter between the MAC and HDLC engines
module rqfc_arb
   import rqfc_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input rqfc_xfer_req_t mac_req,
   input rqfc_xfer_req_t hdlc_req,
   output logic mac_gnt,
   output logic hdlc_gnt,
   output rqfc_xfer_req_t sdram_req,
   input wire logic sdram_done,
   input wire logic [31:0] sdram_rdata,
   output logic [31:0] rdata,
   output logic rdata_valid
);

   typedef struct packed {
      rqfc_owner_t owner;
      logic last_mac;
      rqfc_xfer_req_t cmd;
      logic [31:0] rdata;
      logic rvalid;
   } rqfc_arb_state_t;

   rqfc_arb_state_t s_q;
   rqfc_arb_state_t s_d;

   // ------------------------------------------------------------
   // Round-robin so neither engine can starve the other
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      unique case (s_q.owner)
         RQFC_OWN_IDLE:
         begin
            if (mac_req.req && (!hdlc_req.req || !s_q.last_mac))
            begin
               s_d.owner = RQFC_OWN_MAC;
               s_d.cmd = mac_req;
               s_d.last_mac = 1'b1;
            end
            else if (hdlc_req.req)
            begin
               s_d.owner = RQFC_OWN_HDLC;
               s_d.cmd = hdlc_req;
               s_d.last_mac = 1'b0;
            end
         end
         RQFC_OWN_MAC, RQFC_OWN_HDLC:
         begin
            if (sdram_done)
            begin
               s_d.owner = RQFC_OWN_IDLE;
               s_d.cmd.req = 1'b0;
               s_d.rdata = sdram_rdata;
               s_d.rvalid = !s_q.cmd.wr;
            end
         end
         default:
         begin
            s_d.owner = RQFC_OWN_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Grant is a one-cycle pulse when a request is taken
   assign mac_gnt = (s_q.owner == RQFC_OWN_IDLE) &&
                    (s_d.owner == RQFC_OWN_MAC);
   assign hdlc_gnt = (s_q.owner == RQFC_OWN_IDLE) &&
                     (s_d.owner == RQFC_OWN_HDLC);
   assign sdram_req = s_q.cmd;
   assign rdata = s_q.rdata;
   assign rdata_valid = s_q.rvalid;

endmodule : rqfc_arb

// ==== sim/rqfc_monitor.sv ====
// Checker on the ports of the receive-queue flow control top
module rqfc_monitor
   import rqfc_pkg::*;
#(
   parameter int unsigned OCC_W = RQFC_OCC_W
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic auto_backpressure_enable,
   input wire logic full_duplex,
   input wire logic rx_frame_start,
   input wire logic rx_enqueue,
   input wire logic status_read,
   input wire logic pause_sent,
   input wire logic pause_response_ctrl,
   input wire logic rx_pause_received,
   input wire logic [15:0] rx_pause_quanta,
   input wire logic [OCC_W-1:0] rx_queue_high_threshold,
   input logic [OCC_W-1:0] rx_occupancy,
   input logic pause_send_req,
   input logic [47:0] pause_dest_addr,
   input logic jam_active,
   input logic tx_hold,
   input logic flow_ctrl_enable,
   input logic rx_queue_overflow_flag,
   input logic rx_above_high
);
   timeunit 1ns;
   timeprecision 1ns;

   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_auto_fce: assert property (
      $past(auto_backpressure_enable) && auto_backpressure_enable
      |-> flow_ctrl_enable) else $error("flow enable not forced");
   chk_pause_req: assert property (
      rx_frame_start && rx_above_high && full_duplex && flow_ctrl_enable
      && auto_backpressure_enable |=> pause_send_req)
      else $error("no pause for frame above threshold");
   chk_pause_hold: assert property (
      pause_send_req && !pause_sent |=> pause_send_req)
      else $error("pause request dropped early");
   chk_pause_addr: assert property (
      pause_dest_addr == RQFC_PAUSE_DA) else $error("bad pause address");
   chk_jam_len: assert property (
      $rose(jam_active) |-> jam_active[*4] ##1 !jam_active)
      else $error("jam length not four");
   chk_jam_cause: assert property (
      $rose(jam_active) |-> $past(rx_frame_start) && !$past(full_duplex))
      else $error("jam without half duplex frame start");
   chk_ovf_keep: assert property (
      rx_queue_overflow_flag && !status_read |=> rx_queue_overflow_flag)
      else $error("overflow flag lost");
   chk_above_calc: assert property (
      $past(rx_enqueue) |->
      rx_above_high == (rx_occupancy > rx_queue_high_threshold))
      else $error("threshold state wrong");
   chk_hold_start: assert property (
      rx_pause_received && pause_response_ctrl && rx_pause_quanta != 0
      |=> tx_hold) else $error("received pause not honoured");
endmodule : rqfc_monitor

bind rqfc_top rqfc_monitor #(.OCC_W(OCC_W)) u_rqfc_monitor (.*);

// ==== sim/rqfc_far_end.sv ====
// Far-end model: answers pause requests and SDRAM accesses
module rqfc_far_end
   import rqfc_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic pause_send_req,
   input rqfc_xfer_req_t sdram_req,
   output logic pause_sent,
   output logic sdram_done,
   output logic [31:0] sdram_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] pc_q;
   logic [3:0] sc_q;
   logic [3:0] lim;

   // Slow mode stretches both answers to expose hold problems
   assign lim = slow ? 4'h6 : 4'h1;
   // Released bus shows the inverse word so stale data is caught
   assign sdram_rdata = sdram_done ? 32'hA5A5_5A5A : 32'h5A5A_A5A5;

   // Answer a standing request once it has waited lim cycles
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pc_q <= '0;
         sc_q <= '0;
         pause_sent <= 1'b0;
         sdram_done <= 1'b0;
      end
      else
      begin
         pc_q <= (pause_send_req && !pause_sent) ? pc_q + 4'h1 : '0;
         sc_q <= (sdram_req.req && !sdram_done) ? sc_q + 4'h1 : '0;
         pause_sent <= pause_send_req && !pause_sent && pc_q == lim;
         sdram_done <= sdram_req.req && !sdram_done && sc_q == lim;
      end
   end
endmodule : rqfc_far_end

// ==== sim/testbench.sv ====
// Self-checking bench for the receive-queue flow control block
module testbench import rqfc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, resetn, slow, auto_backpressure_enable;
   logic host_flow_ctrl_enable, host_pause_request, jam_enable;
   logic pause_response_ctrl, full_duplex, status_read, rx_frame_start;
   logic rx_enqueue, rx_dequeue, tx_enqueue, tx_dequeue, slot_tick;
   logic rx_pause_received, pause_sent, sdram_done, pause_send_req;
   logic jam_active, rx_frame_drop, tx_hold, flow_ctrl_enable;
   logic pause_request_busy, rx_queue_overflow_flag, rx_high_latched;
   logic rx_low_latched, rx_above_high, tx_high_latched, tx_low_latched;
   logic mac_gnt, hdlc_gnt, sdram_rdata_valid;
   logic [7:0] rx_queue_size;
   logic [13:0] rx_queue_high_threshold, rx_queue_low_threshold;
   logic [13:0] tx_queue_high_threshold, tx_queue_low_threshold;
   logic [13:0] rx_occupancy;
   logic [15:0] pause_time, rx_pause_quanta, pause_quanta;
   logic [31:0] sdram_rdata, sdram_rdata_q;
   logic [47:0] pause_dest_addr;
   rqfc_xfer_req_t mac_req, hdlc_req, sdram_req;
   int err_total, tests_run, c;

   rqfc_top i_rqfc_top (.*);
   rqfc_far_end i_rqfc_far_end (.*);

   // 50 MHz clock
   initial
   begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task chk(input logic [47:0] g, e);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   // Back-to-back enqueue or dequeue pulses
   task q(input int n, input bit up);
      @(negedge core_clk);
      rx_enqueue = up;
      rx_dequeue = !up;
      repeat (n) @(negedge core_clk);
      rx_enqueue = 0;
      rx_dequeue = 0;
   endtask : q

   task fs;
      @(negedge core_clk);
      rx_frame_start = 1;
      @(negedge core_clk);
      rx_frame_start = 0;
   endtask : fs

   // Frame start, then pause state and number of jammed cycles
   task fr(input logic p, input int j);
      fs;
      chk(pause_send_req, p);
      c = 0;
      repeat (8)
      begin
         c += (jam_active === 1'b1);
         @(negedge core_clk);
      end
      chk(48'(c), 48'(j));
      chk(pause_send_req, 0);
   endtask : fr

   // Hold the request until the grant edge, then await read data
   task arb(input bit h);
      rqfc_xfer_req_t r;
      r = '{1'b1, 1'b0, 23'h00_0010, 32'h0000_0000};
      @(negedge core_clk);
      if (h)
         hdlc_req = r;
      else
         mac_req = r;
      c = 0;
      do
      begin
         @(posedge core_clk);
         c++;
      end while ((h ? hdlc_gnt : mac_gnt) !== 1'b1 && c < 20);
      chk(h ? hdlc_gnt : mac_gnt, 1);
      @(negedge core_clk);
      mac_req = '0;
      hdlc_req = '0;
      chk(sdram_req.addr, 23'h00_0010);
      c = 0;
      while (sdram_rdata_valid !== 1'b1 && c < 20)
      begin
         @(negedge core_clk);
         c++;
      end
      chk(sdram_rdata_valid, 1);
      chk(sdram_rdata_q, 32'hA5A5_5A5A);
   endtask : arb

   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial
   begin
      {resetn, slow, host_flow_ctrl_enable, host_pause_request} = '0;
      {jam_enable, pause_response_ctrl, status_read, rx_frame_start} = '0;
      {rx_enqueue, rx_dequeue, tx_enqueue, tx_dequeue} = '0;
      {slot_tick, rx_pause_received, mac_req, hdlc_req} = '0;
      auto_backpressure_enable = 1;
      full_duplex = 1;
      rx_queue_size = 8'h02;
      rx_queue_high_threshold = 14'h0004;
      rx_queue_low_threshold = 14'h0002;
      tx_queue_high_threshold = 14'h0003;
      tx_queue_low_threshold = 14'h0001;
      pause_time = 16'h0050;
      rx_pause_quanta = 16'h0002;
      repeat (6) @(negedge core_clk);
      chk(flow_ctrl_enable, 1);
      resetn = 1;
      fr(0, 0);
      chk(flow_ctrl_enable, 1);
      q(6, 1);
      chk(rx_occupancy, 14'h0006);
      chk(rx_high_latched, 1);
      chk(pause_dest_addr, RQFC_PAUSE_DA);
      chk(pause_quanta, 16'h0050);
      fr(1, 0);
      slow = 1;
      rx_queue_low_threshold = 14'h0005;
      fr(1, 0);
      @(negedge core_clk);
      status_read = 1;
      @(negedge core_clk);
      status_read = 0;
      chk(rx_high_latched, 0);
      $display("test pause done");
      full_duplex = 0;
      fr(0, 4);
      q(3, 0);
      chk(rx_low_latched, 1);
      fr(0, 0);
      q(2, 1);
      chk(jam_active, 0);
      fr(0, 4);
      $display("test jam done");
      auto_backpressure_enable = 0;
      host_flow_ctrl_enable = 1;
      jam_enable = 1;
      q(3, 0);
      fr(0, 4);
      host_flow_ctrl_enable = 0;
      @(negedge core_clk);
      @(negedge core_clk);
      chk(flow_ctrl_enable, 0);
      fr(0, 0);
      auto_backpressure_enable = 1;
      jam_enable = 0;
      @(negedge core_clk);
      @(negedge core_clk);
      chk(flow_ctrl_enable, 1);
      $display("test manual done");
      full_duplex = 1;
      q(62, 1);
      fs;
      chk(rx_frame_drop, 1);
      chk(rx_queue_overflow_flag, 1);
      q(1, 1);
      chk(rx_occupancy, 14'h0040);
      q(1, 0);
      repeat (10) @(negedge core_clk);
      fs;
      chk(rx_frame_drop, 0);
      chk(rx_queue_overflow_flag, 1);
      $display("test overflow done");
      repeat (10) @(negedge core_clk);
      pause_response_ctrl = 1;
      rx_pause_received = 1;
      @(negedge core_clk);
      rx_pause_received = 0;
      chk(tx_hold, 1);
      slot_tick = 1;
      repeat (2) @(negedge core_clk);
      slot_tick = 0;
      @(negedge core_clk);
      chk(tx_hold, 0);
      pause_response_ctrl = 0;
      rx_pause_received = 1;
      @(negedge core_clk);
      rx_pause_received = 0;
      @(negedge core_clk);
      chk(tx_hold, 0);
      $display("test pause response done");
      // Host pause bit is ignored in automatic mode, obeyed in manual
      host_pause_request = 1;
      repeat (3) @(negedge core_clk);
      chk(pause_request_busy, 0);
      auto_backpressure_enable = 0;
      host_flow_ctrl_enable = 1;
      @(negedge core_clk);
      host_pause_request = 0;
      chk(pause_request_busy, 1);
      repeat (12) @(negedge core_clk);
      chk(pause_send_req, 0);
      chk(rx_above_high, 1);
      auto_backpressure_enable = 1;
      host_flow_ctrl_enable = 0;
      $display("test host pause done");
      // Transmit queue crosses both thresholds without backpressure
      tx_enqueue = 1;
      repeat (4) @(negedge core_clk);
      tx_enqueue = 0;
      chk(tx_high_latched, 1);
      tx_dequeue = 1;
      repeat (4) @(negedge core_clk);
      tx_dequeue = 0;
      chk(tx_low_latched, 1);
      chk(pause_request_busy, 0);
      $display("test tx queue done");
      arb(0);
      slow = 0;
      arb(1);
      $display("test arbiter done");
      print_verdict;
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge core_clk);
      err_total++;
      print_verdict;
   end
endmodule : testbench
